// File: hw/substream_demux_entropy_parser.sv
// Function
// [RQ1] RGB or version one: levels straight from table
// [RQ2] Version two, equal depths: chroma level minus one
// [RQ3] Table covers qp up to depth limit
// [RQ4] Slice split into three or four substreams
// [RQ5] Slice bits taken from picture stream
// [RQ6] Request word when fill minus size below maximum
// [RQ7] Words served luma, orange, green, second luma
// [RQ8] Constant rate: discard trailing zero padding
// [RQ9] Variable rate: strip no padding
// [RQ10] Groups in sequence, flatness bits first
// [RQ11] Deliver residuals and history indices per group
// [RQ12] Report used and ideal bits per group
// [RQ13] Partial last group still gives three values
// [RQ14] Edge residuals give no pixel, still used
// [RQ15] Rate buffer overflow is an error
// [RQ16] Error on reading past slice end
// [RQ17] Fixed length, or transport gives variable length
// [RQ18] Absent flatness type reads as somewhat flat
// [RQ19] Errors sticky until next slice restart
//
// The APB interface to the registers and the register offsets were decided locally.
`timescale 1ns/1ps
`include "substream_demux_defines.svh"

module substream_demux_entropy_parser (
    input wire logic pclk, // Decoder clock, 25 MHz
    input wire logic presetn, // Asynchronous reset, active low
    input wire logic ce, // Clock enable, freezes all state when low
    input wire logic [7:0] paddr, // APB byte address
    input wire logic psel, // APB select
    input wire logic penable, // APB access phase
    input wire logic pwrite, // APB write
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error for unmapped address
    input wire logic in_valid, // Rate buffer word available
    input wire logic [`WORD_W-1:0] in_word, // Rate buffer word
    output logic in_ready, // Word taken this cycle
    input wire logic rb_overflow, // Rate buffer overflow level
    input wire logic slice_start, // Slice restart pulse
    input wire logic [31:0] slice_len_bits, // Slice length in bits, variable rate
    input wire logic slice_last, // Parser finished slice pulse
    input wire logic grp_valid, // Group parsed by substream processors
    output logic grp_ready, // Group accepted
    input wire logic [4*`SIZE_W-1:0] grp_sizes, // Bits decoded per lane
    input wire logic [4*`SIZE_W-1:0] grp_ideal, // Ideal bits per lane
    input wire logic grp_flat_coded, // Flatness type present in stream
    input wire logic grp_flat_kind, // Coded flatness type
    input wire logic grp_hist_mode, // Group coded as history indices
    input wire logic [47:0] grp_residuals, // Three 16-bit residuals
    input wire logic [14:0] grp_hist_idx, // Three 5-bit history indices
    input wire logic [1:0] grp_pix_count, // Pixels inside slice, 1 to 3
    input wire logic [`QP_W-1:0] master_quant_param, // Master qp from rate control
    output logic [`QL_W-1:0] luma_quant_level, // Luma level
    output logic [`QL_W-1:0] chroma_quant_level, // Chroma level
    output logic word_valid, // Word handed to a lane, pulse
    output logic [1:0] word_lane, // 0 luma, 1 orange, 2 green, 3 second luma
    output logic [`WORD_W-1:0] word_data, // Handed word
    output logic res_valid, // Group results valid, pulse
    output logic [47:0] res_data, // Residuals, all three
    output logic [14:0] hist_data, // History indices
    output logic hist_mode, // Group uses history indices
    output logic [2:0] pix_mask, // Pixel positions inside slice
    output logic [15:0] group_bits_used, // Bits consumed by group
    output logic [15:0] group_bits_ideal, // Bits with ideal sizes
    output logic flat_kind, // Flatness type, 0 somewhat flat
    output logic err_overflow, // Sticky overflow error
    output logic err_overread, // Sticky over-read error
    output logic irq // Level interrupt
);

    ////////////////////////////////////////////////////////////////////////
    // Level table: fixed head pattern, then an eight-entry tail per depth
    function automatic logic [`QL_W-1:0] map_level(
        input logic [`QP_W-1:0] qp,
        input logic [2:0] dsel,
        input logic luma
    );
        logic [5:0] top;
        logic [5:0] q;
        logic [5:0] base;
        logic [2:0] k;
        logic [5:0] v;
        top = 6'h0f + {1'b0, dsel, 2'b00};
        q = ({1'b0, qp} > top) ? top : {1'b0, qp};
        base = (top - 6'h08) >> 1;
        k = 3'(q - (top - 6'h07));
        if (q == 6'h00) begin
            v = 6'h00;
        end else if (q < top - 6'h07) begin
            v = luma ? ((q - 6'h01) >> 1) : ((q >> 1) + 6'h01);
        end else if (luma) begin
            case (k)
                3'h0: v = base;
                3'h1, 3'h2: v = base + 6'h01;
                3'h3, 3'h4, 3'h5: v = base + 6'h02;
                3'h6: v = base + 6'h03;
                default: v = base + 6'h04;
            endcase
        end else begin
            case (k)
                3'h0, 3'h1: v = base + 6'h02;
                3'h2, 3'h3: v = base + 6'h03;
                3'h4: v = base + 6'h04;
                default: v = base + 6'h05;
            endcase
        end
        map_level = v[`QL_W-1:0];
    endfunction : map_level

    ////////////////////////////////////////////////////////////////////////
    // State
    substream_demux_pkg::state_type s_q; // Registered state
    substream_demux_pkg::state_type s_d; // Next state
    logic vbr; // Variable rate mode
    logic four; // Second luma substream in use
    logic [3:0] used_lanes; // Lanes active this slice
    logic [1:0] sel_lane; // First pending lane
    logic in_take; // Word handshake
    logic grp_take; // Group handshake
    logic [15:0] sum_used; // Bits of this group
    logic [15:0] sum_ideal; // Ideal bits of this group
    logic [31:0] used_next; // Slice bits after this group
    logic [`QL_W-1:0] cq_raw; // Chroma level from table
    logic apb_wr; // APB write strobe
    logic mapped; // Address decodes to a register

    assign vbr = s_q.ctrl[`CTRL_VBR];
    assign four = s_q.ctrl[`CTRL_FOUR];
    assign used_lanes = four ? 4'hf : 4'h7; // RQ4
    assign in_take = in_valid && in_ready;
    assign grp_take = grp_valid && grp_ready;
    assign apb_wr = psel && penable && pwrite && pready;

    ////////////////////////////////////////////////////////////////////////
    // Lowest pending lane wins, so simultaneous requests follow stream order
    always_comb begin
        sel_lane = 2'h3;
        for (int i = 3; i >= 0; i--) begin
            if (s_q.pend[i]) begin
                sel_lane = 2'(i); // RQ7
            end
        end
    end

    // Group bit sums
    always_comb begin
        sum_used = 16'h0000;
        sum_ideal = 16'h0000;
        for (int i = 0; i < 4; i++) begin
            sum_used = sum_used + 16'(grp_sizes[i*`SIZE_W +: `SIZE_W]); // RQ12
            sum_ideal = sum_ideal + 16'(grp_ideal[i*`SIZE_W +: `SIZE_W]); // RQ12
        end
        used_next = s_q.used_bits + 32'(sum_used);
    end

    // Handshakes; the parser stalls until all pending words arrived
    assign in_ready = ce && ((s_q.phase == substream_demux_pkg::RUN && |s_q.pend)
                             || s_q.phase == substream_demux_pkg::FLUSH);
    assign grp_ready = ce && s_q.phase == substream_demux_pkg::RUN && s_q.pend == 4'h0; // RQ10

    // Address decode
    always_comb begin
        case (paddr)
            `OFS_CTRL, `OFS_QLEVEL, `OFS_SLICE, `OFS_STATUS,
            `OFS_CLEAR, `OFS_IRQ_EN, `OFS_COUNT: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    assign cq_raw = map_level(master_quant_param, s_q.ctrl[`CTRL_DEPTH_HI:`CTRL_DEPTH_LO], 1'b0);

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        s_d = s_q;
        s_d.word_valid = 1'b0;
        s_d.res_valid = 1'b0;
        // Quantization levels, one cycle behind the master qp
        s_d.lq = map_level(master_quant_param, s_q.ctrl[`CTRL_DEPTH_HI:`CTRL_DEPTH_LO], 1'b1); // RQ3
        s_d.cq = cq_raw; // RQ1
        if (!s_q.ctrl[`CTRL_RGB] && s_q.ctrl[`CTRL_VER_HI:`CTRL_VER_LO] == `VER_TWO
            && s_q.ctrl[`CTRL_MATCH]) begin
            s_d.cq = (cq_raw == '0) ? '0 : cq_raw - `QL_W'(1); // RQ2
        end
        // Register writes; clear register is write-only
        if (apb_wr) begin
            case (paddr)
                `OFS_CTRL: s_d.ctrl = pwdata[`CTRL_W-1:0];
                `OFS_SLICE: s_d.slice_cfg = pwdata;
                `OFS_CLEAR: s_d.irq_st = s_q.irq_st & ~pwdata[`IRQ_W-1:0];
                `OFS_IRQ_EN: s_d.irq_en = pwdata[`IRQ_W-1:0];
                default: s_d.irq_en = s_q.irq_en;
            endcase
        end
        // Read data captured in the setup cycle, so no wait state is needed
        if (psel && !penable) begin
            case (paddr)
                `OFS_CTRL: s_d.prdata = 32'(s_q.ctrl);
                `OFS_QLEVEL: s_d.prdata = {22'h000000, s_q.lq, s_q.cq};
                `OFS_SLICE: s_d.prdata = s_q.slice_cfg;
                `OFS_STATUS: s_d.prdata = 32'(s_q.irq_st);
                `OFS_IRQ_EN: s_d.prdata = 32'(s_q.irq_en);
                `OFS_COUNT: s_d.prdata = s_q.used_bits;
                default: s_d.prdata = 32'h0000_0000;
            endcase
        end
        // Slice restart clears errors; fresh events below still win
        if (slice_start) begin
            s_d.phase = substream_demux_pkg::RUN; // RQ5
            s_d.slice_bits = vbr ? slice_len_bits // RQ17
                : 32'(s_q.slice_cfg[15:0]) * 32'(s_q.slice_cfg[31:16]) * `BYTE_BITS;
            s_d.in_bits = 32'h0000_0000;
            s_d.used_bits = 32'h0000_0000;
            s_d.fill = '0;
            s_d.pend = used_lanes; // RQ4
            s_d.err_ovf = 1'b0; // RQ19
            s_d.err_ovr = 1'b0; // RQ19
        end else begin
            case (s_q.phase)
                substream_demux_pkg::RUN: begin
                    // Hand the word to the first requesting lane
                    if (in_take) begin
                        s_d.word_valid = 1'b1;
                        s_d.word_lane = sel_lane; // RQ7
                        s_d.word_data = in_word;
                        s_d.fill[sel_lane] = s_q.fill[sel_lane] + `FILL_W'(`WORD_W);
                        s_d.pend[sel_lane] = 1'b0;
                        s_d.in_bits = s_q.in_bits + 32'(`WORD_W); // RQ5
                    end
                    // Group done: drain shifters, raise requests, report
                    if (grp_take) begin
                        for (int i = 0; i < 4; i++) begin
                            s_d.fill[i] = s_q.fill[i] - `FILL_W'(grp_sizes[i*`SIZE_W +: `SIZE_W]);
                            s_d.pend[i] = used_lanes[i] && (s_d.fill[i] < `MAX_SE_BITS); // RQ6
                        end
                        s_d.res_valid = 1'b1; // RQ11
                        s_d.res = grp_residuals; // RQ14
                        s_d.hist = grp_hist_idx; // RQ13
                        s_d.hist_mode = grp_hist_mode;
                        s_d.pix_mask = (grp_pix_count == 2'h1) ? 3'h1 // RQ14
                            : (grp_pix_count == 2'h2) ? 3'h3 : 3'h7;
                        s_d.used = sum_used; // RQ12
                        s_d.ideal = sum_ideal; // RQ12
                        s_d.flat_kind = grp_flat_coded ? grp_flat_kind : 1'b0; // RQ18
                        s_d.used_bits = used_next;
                        if (used_next > s_q.slice_bits) begin
                            s_d.err_ovr = 1'b1; // RQ16
                            s_d.irq_st[`IRQ_OVERREAD] = 1'b1;
                        end
                    end
                    // End of slice: constant rate drains padding words
                    if (slice_last) begin
                        if (!vbr && s_d.in_bits < s_q.slice_bits) begin
                            s_d.phase = substream_demux_pkg::FLUSH; // RQ8
                        end else begin
                            s_d.phase = substream_demux_pkg::IDLE; // RQ9
                            s_d.irq_st[`IRQ_SLICE_DONE] = 1'b1;
                        end
                        s_d.pend = 4'h0;
                    end
                end
                substream_demux_pkg::FLUSH: begin
                    // Padding words are dropped, nothing reaches the lanes
                    if (in_take) begin
                        s_d.in_bits = s_q.in_bits + 32'(`WORD_W); // RQ8
                        if (s_d.in_bits >= s_q.slice_bits) begin
                            s_d.phase = substream_demux_pkg::IDLE;
                            s_d.irq_st[`IRQ_SLICE_DONE] = 1'b1;
                        end
                    end
                end
                substream_demux_pkg::IDLE: s_d.phase = substream_demux_pkg::IDLE;
                default: s_d.phase = substream_demux_pkg::IDLE;
            endcase
        end
        // Overflow latches in any phase; status sets on its first cycle
        if (rb_overflow) begin
            s_d.err_ovf = 1'b1; // RQ15
            s_d.irq_st[`IRQ_OVERFLOW] = 1'b1;
        end
    end

    // State register; clock enable freezes everything
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    assign prdata = s_q.prdata;
    assign pready = ce;
    assign pslverr = psel && penable && !mapped;
    assign luma_quant_level = s_q.lq;
    assign chroma_quant_level = s_q.cq;
    assign word_valid = s_q.word_valid;
    assign word_lane = s_q.word_lane;
    assign word_data = s_q.word_data;
    assign res_valid = s_q.res_valid;
    assign res_data = s_q.res;
    assign hist_data = s_q.hist;
    assign hist_mode = s_q.hist_mode;
    assign pix_mask = s_q.pix_mask;
    assign group_bits_used = s_q.used;
    assign group_bits_ideal = s_q.ideal;
    assign flat_kind = s_q.flat_kind;
    assign err_overflow = s_q.err_ovf;
    assign err_overread = s_q.err_ovr;
    assign irq = |(s_q.irq_st & s_q.irq_en);

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn || !ce);

    chk_lane_order: assert property (in_take && s_q.phase == substream_demux_pkg::RUN
        && !slice_start && s_q.pend[0] |=> word_valid && word_lane == 2'h0) // RQ7
        else $error("luma request not served first");
    chk_req_raise: assert property (grp_take && !slice_start && !slice_last
        && s_q.fill[0] - `FILL_W'(grp_sizes[`SIZE_W-1:0]) < `MAX_SE_BITS |=> s_q.pend[0]) // RQ6
        else $error("luma lane did not request a word");
    chk_level_eight: assert property (s_q.ctrl[`CTRL_RGB]
        && s_q.ctrl[`CTRL_DEPTH_HI:`CTRL_DEPTH_LO] == 3'h0 && master_quant_param == 5'h0f
        |=> luma_quant_level == 5'h07 && chroma_quant_level == 5'h08) // RQ3
        else $error("wrong levels for top 8-bit qp");
    chk_chroma_trim: assert property (!s_q.ctrl[`CTRL_RGB] && s_q.ctrl[`CTRL_MATCH]
        && s_q.ctrl[`CTRL_VER_HI:`CTRL_VER_LO] == `VER_TWO
        && s_q.ctrl[`CTRL_DEPTH_HI:`CTRL_DEPTH_LO] == 3'h0 && master_quant_param == 5'h0f
        |=> chroma_quant_level == 5'h07) // RQ2
        else $error("chroma level not reduced");
    chk_no_vbr_flush: assert property (s_q.phase == substream_demux_pkg::RUN && slice_last
        && !slice_start && vbr |=> s_q.phase == substream_demux_pkg::IDLE) // RQ9
        else $error("variable rate slice flushed padding");
    chk_overread_flag: assert property (grp_take && !slice_start
        && used_next > s_q.slice_bits |=> err_overread) // RQ16
        else $error("over-read not flagged");
    chk_overflow_hold: assert property (rb_overflow ##1 !slice_start[*2] |=> err_overflow) // RQ19
        else $error("overflow error not held");
    chk_edge_mask: assert property (grp_take && !slice_start && grp_pix_count == 2'h1
        |=> res_valid && pix_mask == 3'h1 && res_data == $past(grp_residuals)) // RQ14
        else $error("edge group output wrong");
    chk_flat_default: assert property (grp_take && !slice_start && !grp_flat_coded
        |=> flat_kind == 1'b0) // RQ18
        else $error("absent flatness type not zero");
    chk_bits_report: assert property (grp_take && !slice_start
        |=> group_bits_used == $past(sum_used) && group_bits_ideal == $past(sum_ideal)) // RQ12
        else $error("group bit counts wrong");

endmodule : substream_demux_entropy_parser

// File: hw/substream_demux_defines.svh
`ifndef SUBSTREAM_DEMUX_DEFINES_SVH
`define SUBSTREAM_DEMUX_DEFINES_SVH

// Register byte offsets
`define OFS_CTRL 8'h00
`define OFS_QLEVEL 8'h04
`define OFS_SLICE 8'h08
`define OFS_STATUS 8'h0c
`define OFS_CLEAR 8'h10
`define OFS_IRQ_EN 8'h14
`define OFS_COUNT 8'h18

// Control register fields
`define CTRL_VBR 0
`define CTRL_RGB 1
`define CTRL_FOUR 2
`define CTRL_MATCH 3
`define CTRL_DEPTH_LO 4
`define CTRL_DEPTH_HI 6
`define CTRL_VER_LO 8
`define CTRL_VER_HI 11
`define CTRL_W 12
`define CTRL_RST 12'h000

// Interrupt status bits
`define IRQ_OVERFLOW 0
`define IRQ_OVERREAD 1
`define IRQ_SLICE_DONE 2
`define IRQ_W 3

// Datapath widths and limits
`define WORD_W 32
`define FILL_W 8
`define SIZE_W 6
`define QP_W 5
`define QL_W 5
`define VER_ONE 4'h1
`define VER_TWO 4'h2
`define MAX_SE_BITS 8'h24
`define BYTE_BITS 32'h0000_0008

`endif

// File: hw/substream_demux_pkg.sv
package substream_demux_pkg;
`include "substream_demux_defines.svh"

    // Slice handling phase
    typedef enum logic [1:0] {
        IDLE,
        RUN,
        FLUSH
    } phase_type;

    // Whole state of the block
    typedef struct packed {
        phase_type phase;
        logic [`CTRL_W-1:0] ctrl;
        logic [31:0] slice_cfg;
        logic [`IRQ_W-1:0] irq_st;
        logic [`IRQ_W-1:0] irq_en;
        logic err_ovf;
        logic err_ovr;
        logic [3:0][`FILL_W-1:0] fill;
        logic [3:0] pend;
        logic [31:0] in_bits;
        logic [31:0] used_bits;
        logic [31:0] slice_bits;
        logic word_valid;
        logic [1:0] word_lane;
        logic [`WORD_W-1:0] word_data;
        logic res_valid;
        logic [47:0] res;
        logic [14:0] hist;
        logic hist_mode;
        logic [2:0] pix_mask;
        logic [15:0] used;
        logic [15:0] ideal;
        logic flat_kind;
        logic [`QL_W-1:0] lq;
        logic [`QL_W-1:0] cq;
        logic [31:0] prdata;
    } state_type;

endpackage : substream_demux_pkg

// File: tb/rate_buffer_model.sv
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Rate buffer on the far side: offers slice words one at a time
module rate_buffer_model (
    input wire logic pclk, // Decoder clock
    input wire logic presetn, // Asynchronous reset, active low
    input wire logic in_ready, // Word taken this cycle
    input wire logic stall, // Bench asks for an empty cycle
    output logic in_valid, // Word on offer
    output logic [31:0] in_word // Offered word
);
    logic [31:0] lfsr_q; // Next slice word

    // A word on offer holds until taken; an empty cycle shows a changing
    // pattern so a stale word can never pass for fresh data
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            in_valid <= 1'h0;
            in_word <= 32'h0000_0000;
            lfsr_q <= 32'h1357_9bdf;
        end else if (!in_valid || in_ready) begin
            in_valid <= !stall;
            in_word <= stall ? ~in_word : lfsr_q;
            if (!stall) begin
                lfsr_q <= {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
            end
        end
    end
endmodule : rate_buffer_model

// File: tb/substream_demux_entropy_parser_tb_top.sv
`timescale 1ns/1ps
`include "substream_demux_defines.svh"

module substream_demux_entropy_parser_tb_top;
    logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, err, stall, flushing;
    logic in_valid, in_ready, rb_overflow, slice_start, slice_last, grp_valid, grp_ready;
    logic grp_flat_coded, grp_flat_kind, grp_hist_mode, word_valid, res_valid, hist_mode;
    logic flat_kind, err_overflow, err_overread, irq;
    logic [7:0] paddr; // Register byte address
    logic [31:0] pwdata, prdata, rd, in_word, slice_len_bits, word_data;
    logic [23:0] grp_sizes, grp_ideal; // Per-lane sizes
    logic [47:0] grp_residuals, res_data; // Three residuals
    logic [14:0] grp_hist_idx, hist_data; // Three history indices
    logic [1:0] grp_pix_count, word_lane;
    logic [4:0] master_quant_param, luma_quant_level, chroma_quant_level;
    logic [2:0] pix_mask;
    logic [15:0] group_bits_used, group_bits_ideal;
    int mismatches, compares, seed, fill[4];
    int ly[16] = '{0, 0, 0, 1, 1, 2, 2, 3, 3, 4, 4, 5, 5, 5, 6, 7}; // Luma level, 8 bit
    int lc[16] = '{0, 1, 2, 2, 3, 3, 4, 4, 5, 5, 6, 6, 7, 8, 8, 8}; // Chroma level, 8 bit
    logic [1:0] lane_q[$]; // Expected lane of each handed word
    logic [31:0] data_q[$]; // Words taken from the rate buffer
    logic [99:0] res_q[$]; // Expected group results

    substream_demux_entropy_parser uut (.pclk, .presetn, .ce, .paddr, .psel, .penable, .pwrite,
        .pwdata, .prdata, .pready, .pslverr, .in_valid, .in_word, .in_ready, .rb_overflow,
        .slice_start, .slice_len_bits, .slice_last, .grp_valid, .grp_ready, .grp_sizes,
        .grp_ideal, .grp_flat_coded, .grp_flat_kind, .grp_hist_mode, .grp_residuals,
        .grp_hist_idx, .grp_pix_count, .master_quant_param, .luma_quant_level,
        .chroma_quant_level, .word_valid, .word_lane, .word_data, .res_valid, .res_data,
        .hist_data, .hist_mode, .pix_mask, .group_bits_used, .group_bits_ideal, .flat_kind,
        .err_overflow, .err_overread, .irq);
    rate_buffer_model rbm (.pclk, .presetn, .in_ready, .stall, .in_valid, .in_word);

    ////////////////////////////////////////////////////////////////////////////
    // Clock, 40 ns period
    initial begin
        pclk = 1'h0;
        forever #20 pclk = ~pclk;
    end

    // Random empty cycles from the rate buffer
    always @(posedge pclk) stall <= 1'($random(seed));

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [99:0] got, input logic [99:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic end_of_test;
        if (mismatches == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : end_of_test

    task automatic fail;
        mismatches++;
        $display("[FAIL] %0t wait ran out", $time);
        end_of_test();
    endtask : fail

    // Words taken outside a flush must come back out, in lane order
    always @(posedge pclk) begin
        if (in_valid && in_ready && !flushing) data_q.push_back(in_word);
        if (word_valid && lane_q.size() == 0) chk(1'h1, 1'h0);
        else if (word_valid) chk({word_lane, word_data}, {lane_q.pop_front(), data_q.pop_front()});
        if (res_valid) chk({res_data, hist_data, hist_mode, pix_mask, group_bits_used,
            group_bits_ideal, flat_kind}, res_q.pop_front());
    end

    ////////////////////////////////////////////////////////////////////////////
    // One APB transfer; pready decides when it ends, never a fixed count
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'h1, 1'h0, w, a, d};
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1 && ++n < 20);
        if (n >= 20) fail();
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'h0;
    endtask : apb

    task automatic qp(input logic [11:0] c, input logic trim);
        apb(1'h1, `OFS_CTRL, 32'(c));
        apb(1'h0, `OFS_CTRL, 32'h0);
        chk(rd, 32'(c));
        for (int q = 0; q < 16; q++) begin
            master_quant_param <= 5'(q);
            repeat (2) @(posedge pclk);
            chk({luma_quant_level, chroma_quant_level}, {5'(ly[q]), 5'(lc[q] - (trim && lc[q] > 0))});
        end
    endtask : qp

    task automatic slice(input int lanes, input int len);
        flushing = 1'h0;
        for (int i = 0; i < lanes; i++) begin
            fill[i] = 32;
            lane_q.push_back(2'(i));
        end
        @(posedge pclk);
        {slice_start, slice_len_bits} <= {1'h1, 32'(len)};
        @(posedge pclk);
        slice_start <= 1'h0;
    endtask : slice

    // One group; lane sizes lie between lo and 20 so every fill stays positive
    task automatic grp(input int lanes, input int lo, input logic [1:0] pe = 2'h0);
        logic [23:0] sz = '0, id;
        logic [47:0] r;
        logic [14:0] hx;
        logic [1:0] pc;
        logic hm, cd, kd;
        int n = 0, u = 0, iu = 0;
        {id, r, hx, pc, hm, cd, kd} = {$random(seed), $random(seed), $random(seed), $random(seed)};
        if (pe != 2'h0) pc = pe;
        for (int i = 0; i < 4; i++) begin
            if (i < lanes) sz[i*6+:6] = 6'(lo + {$random(seed)} % (21 - lo));
            u += sz[i*6+:6];
            iu += id[i*6+:6];
        end
        res_q.push_back({r, hx, hm, pc == 1 ? 3'h1 : pc == 2 ? 3'h3 : 3'h7, 16'(u), 16'(iu), cd & kd});
        @(posedge pclk);
        {grp_valid, grp_sizes, grp_ideal, grp_residuals, grp_hist_idx, grp_pix_count, grp_hist_mode,
            grp_flat_coded, grp_flat_kind} <= {1'h1, sz, id, r, hx, pc, hm, cd, kd};
        do @(posedge pclk); while (grp_ready !== 1'h1 && ++n < 99);
        if (n >= 99) fail();
        grp_valid <= 1'h0;
        for (int i = 0; i < lanes; i++) begin
            fill[i] -= sz[i*6+:6];
            if (fill[i] < 36) begin
                fill[i] += 32;
                lane_q.push_back(2'(i));
            end
        end
    endtask : grp

    task automatic waitq;
        int n = 0;
        while (lane_q.size() != 0 && n++ < 300) @(posedge pclk);
        if (n >= 300) fail();
    endtask : waitq

    // Ends the slice; a flush keeps taking words that never reach a lane
    task automatic end_slice(input logic fl);
        int n = 0;
        flushing = fl;
        @(posedge pclk);
        slice_last <= 1'h1;
        @(posedge pclk);
        slice_last <= 1'h0;
        @(posedge pclk);
        chk(in_ready, fl);
        while (in_ready !== 1'h0 && n++ < 99) @(posedge pclk);
        if (n >= 99) fail();
    endtask : end_slice

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        {psel, penable, pwrite, paddr, pwdata, rb_overflow, slice_start, slice_last} = '0;
        {slice_len_bits, grp_valid, grp_sizes, grp_ideal, grp_flat_coded, grp_flat_kind} = '0;
        {grp_hist_mode, grp_residuals, grp_hist_idx, grp_pix_count, master_quant_param} = '0;
        {mismatches, compares, flushing, presetn, ce} = 2'h1;
        seed = 24;
        repeat (2) @(posedge pclk);
        presetn <= 1'h1;
        // Every word reads zero after reset; the word past the map is refused
        for (int a = 0; a < 8; a++) begin
            apb(1'h0, 8'(a * 4), 32'h0);
            chk({err, rd}, {a == 7, 32'h0});
        end
        apb(1'h1, `OFS_IRQ_EN, 32'h1);
        @(posedge pclk);
        rb_overflow <= 1'h1;
        @(posedge pclk);
        rb_overflow <= 1'h0;
        @(posedge pclk);
        chk({err_overflow, irq}, 2'h3);
        apb(1'h1, `OFS_CLEAR, 32'h1);
        @(posedge pclk);
        chk({err_overflow, irq}, 2'h2);
        qp(12'h100, 1'h0);
        qp(12'h002, 1'h0);
        qp(12'h208, 1'h1);
        qp(12'h200, 1'h0);
        // Constant rate, three lanes, 48 bytes: the tail must be flushed
        apb(1'h1, `OFS_SLICE, 32'h0001_0030);
        apb(1'h1, `OFS_CTRL, 32'h0);
        slice(3, 0);
        grp(3, 0);
        grp(3, 0, 2'h1);
        waitq();
        end_slice(1'h1);
        apb(1'h0, `OFS_STATUS, 32'h0);
        chk(rd, 32'h4);
        // Variable rate, four lanes, a 40-bit slice that the group overruns
        apb(1'h1, `OFS_CTRL, 32'h5);
        slice(4, 40);
        grp(4, 12);
        waitq();
        chk(err_overread, 1'h1);
        end_slice(1'h0);
        apb(1'h1, `OFS_IRQ_EN, 32'h7);
        apb(1'h0, `OFS_STATUS, 32'h0);
        chk({irq, rd}, {1'h1, 32'h6});
        apb(1'h1, `OFS_CLEAR, 32'h7);
        @(posedge pclk);
        chk({irq, err_overread}, 2'h1);
        slice(4, 0);
        @(posedge pclk);
        chk(err_overread, 1'h0);
        waitq();
        end_of_test();
    end
endmodule : substream_demux_entropy_parser_tb_top
